// ==== shared/mech_defs.vh ====
`ifndef MECH_DEFS_VH
`define MECH_DEFS_VH
`define MECH_FC_ENCAP 8'h7d
`define MECH_FC_NOP 8'h7e
`define MECH_ERR_FLAG 8'h80
`define MECH_EXC_ILLEGAL_FN 8'h01
`define MECH_STAT_SEL_BIT 3
`define MECH_MAX_DATA 250
`define MECH_CRC_INIT 16'hffff
`define MECH_CRC_POLY 16'ha001
`endif

// ==== design/mech_crc16.v ====
`timescale 1ns/1ns
// running modbus crc-16, lsb first, one byte per cycle
module mech_crc16 (
  input wire clock,
  input wire clear,
  input wire en,
  input wire [7:0] data,
  output reg [15:0] crc_q
);
`include "mech_defs.vh"
  function [15:0] crc_step;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1) begin
        t = t[0] ? ((t >> 1) ^ `MECH_CRC_POLY) : (t >> 1);
      end
      crc_step = t;
    end
  endfunction

  always @(posedge clock) begin
    if (clear) begin
      crc_q <= `MECH_CRC_INIT;
    end else if (en) begin
      crc_q <= crc_step(crc_q, data);
    end
  end
endmodule // mech_crc16

// ==== design/mech_handler.v ====
`timescale 1ns/1ns
`include "mech_defs.vh"
// Functional notes
// - query: addr, 7Dh, control, function, data, crc
// - control word acts as command write
// - status word picked by control bit 3
// - success sends addr, 7Dh, status, function, engine data, crc
// - error gives flagged function and code
// - unknown function: illegal code, count it
// - supported function failure reports its code
// - 7Eh is no-op, only inside 7Dh
// - no-op reply carries no data bytes
// - command write replaces all output bits
module mech_handler #(
  parameter MAX_DATA = `MECH_MAX_DATA
) (
  input wire clock,
  input wire rst,
  input wire [7:0] own_addr,
  // received bytes of one frame; rx_end after last (crc) byte
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_end,
  // embedded function engine
  output reg emb_req,
  output reg [7:0] emb_func,
  output reg [7:0] emb_len,
  output reg [7:0] emb_rd_idx,
  output wire [7:0] emb_rd_data,
  input wire emb_done,
  input wire emb_supported,
  input wire emb_error,
  input wire [7:0] emb_err_code,
  input wire [7:0] emb_resp_len,
  input wire [7:0] emb_resp_data,
  output reg [7:0] emb_resp_idx,
  // status sources
  input wire [15:0] status_a,
  input wire [15:0] status_b,
  // command register image
  output reg [15:0] logic_cmd,
  output reg logic_cmd_wr,
  output reg [15:0] illegal_fn_count,
  // transmit byte stream
  output reg tx_valid,
  output reg [7:0] tx_data,
  output reg tx_last,
  input wire tx_ready
);
  localparam [7:0] DATA_MAX = MAX_DATA[7:0];
  localparam S_IDLE = 3'd0;
  localparam S_RX = 3'd1;
  localparam S_CHECK = 3'd2;
  localparam S_EXEC = 3'd3;
  localparam S_TX = 3'd4;
  localparam S_DROP = 3'd5;

  reg [2:0] state_q;
  // header, data and both crc bytes of the longest frame
  reg [7:0] buf_q [0:MAX_DATA+6];
  reg [8:0] cnt_q;
  reg [8:0] tx_idx_q;
  reg [8:0] tx_total_q;
  reg [15:0] status_q;
  reg err_q;
  reg [7:0] err_code_q;
  wire tx_load;
  wire [7:0] resp_len_clip;
  reg crc_clr;
  reg crc_en;
  reg [7:0] crc_in;
  wire [15:0] crc;
  reg [7:0] byte_d;

  mech_crc16 u_crc (
    .clock(clock),
    .clear(crc_clr),
    .en(crc_en),
    .data(crc_in),
    .crc_q(crc)
  );

  assign emb_rd_data = buf_q[emb_rd_idx + 8'd5];

  // a byte is loaded while the stream is empty or its current byte is taken, unless that was the tx_last byte
  assign tx_load = (state_q == S_TX) && (!tx_valid || tx_ready) && !(tx_valid && tx_last);
  // longer answers are clipped so the frame stays legal
  assign resp_len_clip = (emb_resp_len > DATA_MAX) ? DATA_MAX : emb_resp_len;

  // response byte by position
  always @* begin
    emb_resp_idx = 8'h00;
    if (tx_idx_q == 9'd0) byte_d = own_addr;
    else if (tx_idx_q == 9'd1) byte_d = `MECH_FC_ENCAP;
    else if (tx_idx_q == 9'd2) byte_d = status_q[15:8];
    else if (tx_idx_q == 9'd3) byte_d = status_q[7:0];
    else if (tx_idx_q == 9'd4) byte_d = err_q ? (emb_func | `MECH_ERR_FLAG) : emb_func;
    else if (err_q && tx_idx_q == 9'd5) byte_d = err_code_q;
    else if (tx_idx_q == tx_total_q - 9'd2) byte_d = crc[7:0];
    else if (tx_idx_q == tx_total_q - 9'd1) byte_d = crc[15:8];
    else begin
      emb_resp_idx = tx_idx_q[7:0] - 8'd5;
      byte_d = emb_resp_data;
    end
  end

  always @* begin
    // clear between frames; a byte arriving in idle must not be eaten by the clear
    crc_clr = (state_q == S_CHECK) || (state_q == S_EXEC) || (state_q == S_DROP)
      || (state_q == S_IDLE && !rx_valid);
    crc_en = 1'b0;
    crc_in = rx_data;
    if (state_q == S_IDLE || state_q == S_RX) begin
      crc_en = rx_valid;
    end else if (state_q == S_TX) begin
      crc_in = byte_d;
      // the crc bytes themselves stay out of the sum
      crc_en = tx_load && (tx_idx_q < tx_total_q - 9'd2);
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      state_q <= S_IDLE;
      cnt_q <= 9'd0;
      tx_idx_q <= 9'd0;
      tx_total_q <= 9'd0;
      status_q <= 16'h0000;
      err_q <= 1'b0;
      err_code_q <= 8'h00;
      emb_req <= 1'b0;
      emb_func <= 8'h00;
      emb_len <= 8'h00;
      emb_rd_idx <= 8'h00;
      logic_cmd <= 16'h0000;
      logic_cmd_wr <= 1'b0;
      illegal_fn_count <= 16'h0000;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_last <= 1'b0;
    end else begin
      logic_cmd_wr <= 1'b0;
      emb_req <= 1'b0;
      case (state_q)
        S_IDLE, S_RX: begin
          if (rx_valid) begin
            // bytes past the longest frame are counted, not stored
            if (cnt_q <= MAX_DATA + 6) begin
              buf_q[cnt_q] <= rx_data;
            end
            cnt_q <= cnt_q + 9'd1;
            state_q <= S_RX;
          end
          if (rx_end) begin
            state_q <= S_CHECK;
          end
        end
        S_CHECK: begin
          // crc over whole frame incl. its crc leaves zero residue
          if (crc != 16'h0000 || buf_q[0] != own_addr || buf_q[1] != `MECH_FC_ENCAP
              || cnt_q < 9'd7 || cnt_q > MAX_DATA + 7) begin
            state_q <= S_DROP;
          end else begin
            // whole word replaces the command image, no bit merging
            logic_cmd <= {buf_q[2], buf_q[3]};
            logic_cmd_wr <= 1'b1;
            status_q <= buf_q[3][`MECH_STAT_SEL_BIT] ? status_a : status_b;
            emb_func <= buf_q[4];
            emb_len <= cnt_q[7:0] - 8'd7;
            err_q <= 1'b0;
            if (buf_q[4] == `MECH_FC_NOP) begin
              tx_total_q <= 9'd7;
              tx_idx_q <= 9'd0;
              state_q <= S_TX;
            end else begin
              emb_req <= 1'b1;
              state_q <= S_EXEC;
            end
          end
        end
        S_EXEC: begin
          if (emb_done) begin
            tx_idx_q <= 9'd0;
            state_q <= S_TX;
            if (!emb_supported) begin
              err_q <= 1'b1;
              err_code_q <= `MECH_EXC_ILLEGAL_FN;
              illegal_fn_count <= illegal_fn_count + 16'd1;
              tx_total_q <= 9'd8;
            end else if (emb_error) begin
              err_q <= 1'b1;
              err_code_q <= emb_err_code;
              tx_total_q <= 9'd8;
            end else begin
              tx_total_q <= 9'd7 + {1'b0, resp_len_clip};
            end
          end
        end
        S_TX: begin
          if (!tx_valid || tx_ready) begin
            if (tx_valid && tx_last) begin
              tx_valid <= 1'b0;
              tx_last <= 1'b0;
              state_q <= S_DROP;
            end else begin
              tx_valid <= 1'b1;
              tx_data <= byte_d;
              tx_last <= (tx_idx_q == tx_total_q - 9'd1);
              tx_idx_q <= tx_idx_q + 9'd1;
            end
          end
        end
        S_DROP: begin
          // frame over: crc is being cleared, next query may start
          cnt_q <= 9'd0;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

endmodule // mech_handler

// ==== dv/mech_chk.sv ====
`timescale 1ns/1ns
module mech_chk(
  input wire clock,
  input wire rst,
  input wire [7:0] own_addr,
  input wire rx_end,
  input wire emb_done,
  input wire emb_supported,
  input wire logic_cmd_wr,
  input wire [15:0] illegal_fn_count,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire tx_last,
  input wire tx_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire bad = emb_done && !emb_supported;
  reg busy_q;
  // high while a reply is mid-stream
  always @(posedge clock) busy_q <= rst ? 1'b0 : (tx_valid && tx_ready ? !tx_last : busy_q);
  wr_lat_a: assert property (logic_cmd_wr |-> $past(rx_end, 2)) else $error("cmd late");
  wr_pulse_a: assert property (logic_cmd_wr |=> !logic_cmd_wr) else $error("cmd wide");
  cnt_inc_a: assert property (bad |-> ##[1:3] $changed(illegal_fn_count)) else $error("no count");
  cnt_step_a: assert property ($changed(illegal_fn_count) |->
    illegal_fn_count == $past(illegal_fn_count) + 16'h1) else $error("count step");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx dropped");
  tx_lead_a: assert property (tx_valid && !busy_q |-> tx_data == own_addr) else $error("addr");
  tx_idle_a: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid) else $error("tail");
  rst_quiet_a: assert property (disable iff (1'b0) rst |=> !tx_valid && illegal_fn_count == 16'h0)
    else $error("reset");
endmodule // mech_chk
bind mech_handler mech_chk u_chk(.clock, .rst, .own_addr, .rx_end, .emb_done, .emb_supported,
  .logic_cmd_wr, .illegal_fn_count, .tx_valid, .tx_data, .tx_last, .tx_ready);

// ==== dv/mech_master.sv ====
`timescale 1ns/1ns
module mech_master(
  input wire clock,
  output reg rx_valid,
  output reg [7:0] rx_data,
  output reg rx_end,
  input wire tx_valid,
  input wire [7:0] tx_data,
  output reg tx_ready
);
  reg [7:0] rq[$];
  bit slow = 0;
  initial {rx_valid, rx_data, rx_end, tx_ready} = 11'h1;
  function automatic [15:0] crc(input [15:0] c, input [7:0] d);
    c = c ^ d;
    repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    return c;
  endfunction
  task send(input [7:0] a, input [15:0] c, input [7:0] f, input int n, input bit bad);
    reg [15:0] s;
    reg [7:0] b[$];
    b = {a, 8'h7d, c[15:8], c[7:0], f};
    for (int i = 0; i < n; i++) b.push_back(i[7:0]);
    s = 16'hffff;
    foreach (b[j]) s = crc(s, b[j]);
    s[0] ^= bad;
    b = {b, s[7:0], s[15:8]};
    rx_valid = 1;
    foreach (b[j]) begin
      rx_data = b[j];
      @(posedge clock) #1;
    end
    // released line shows no stale byte
    rx_valid = 0;
    rx_data = ~rx_data;
    rx_end = 1;
    @(posedge clock) #1;
    rx_end = 0;
  endtask
  always @(posedge clock) begin
    if (tx_valid && tx_ready) rq.push_back(tx_data);
    tx_ready <= #1 slow ? !tx_ready : 1'b1;
  end
endmodule // mech_master

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  typedef struct {bit [15:0] c; bit [7:0] f; int n; bit sup, err; bit [7:0] code, rl;} mech_row_t;
  mech_row_t rows[5] = '{'{16'h0008, 8'h7e, 0, 0, 0, 8'h0, 8'h0},
    '{16'h1200, 8'h03, 4, 1, 0, 8'h0, 8'h05}, '{16'h00f8, 8'h41, 2, 0, 0, 8'h0, 8'h0},
    '{16'h0001, 8'h03, 4, 1, 1, 8'h02, 8'h0}, '{16'h800c, 8'h10, 250, 1, 0, 8'h0, 8'hfa}};
  mech_row_t rw;
  reg clock = 0, rst = 1, emb_done = 0, emb_supported = 0, emb_error = 0;
  reg [7:0] own_addr = 8'h11, emb_err_code = 0, emb_resp_len = 0;
  reg [15:0] status_a = 16'ha1b2, status_b = 16'hc3d4, lc = 0, icnt = 0;
  wire rx_valid, rx_end, emb_req, logic_cmd_wr, tx_valid, tx_last, tx_ready;
  wire [7:0] rx_data, emb_func, emb_len, emb_rd_idx, emb_rd_data, emb_resp_idx, tx_data;
  wire [15:0] logic_cmd, illegal_fn_count;
  wire [7:0] emb_resp_data = emb_resp_idx ^ 8'h5a;
  int miscompares = 0, checks = 0;
  always #5 clock = ~clock;
  mech_master m(.clock, .rx_valid, .rx_data, .rx_end, .tx_valid, .tx_data, .tx_ready);
  mech_handler dut(.clock, .rst, .own_addr, .rx_valid, .rx_data, .rx_end, .emb_req, .emb_func,
    .emb_len, .emb_rd_idx, .emb_rd_data, .emb_done, .emb_supported, .emb_error, .emb_err_code,
    .emb_resp_len, .emb_resp_data, .emb_resp_idx, .status_a, .status_b, .logic_cmd,
    .logic_cmd_wr, .illegal_fn_count, .tx_valid, .tx_data, .tx_last, .tx_ready);
  always @(posedge clock) if (emb_req) begin
    #1 chk(emb_func, rw.f, "embedded function");
    chk(emb_len, rw.n, "embedded length");
    chk(emb_rd_data, 8'h00, "first data byte");
    repeat (3) @(posedge clock);
    #1 {emb_supported, emb_error, emb_err_code, emb_resp_len} = {rw.sup, rw.err, rw.code, rw.rl};
    emb_done = 1;
    @(posedge clock) #1 emb_done = 0;
  end
  task chk(input [15:0] got, input [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task run(input mech_row_t r, input [7:0] a, input bit bad);
    reg [7:0] e[$];
    reg [15:0] s;
    int k;
    rw = r;
    m.rq.delete();
    m.slow = r.rl == 8'h05;
    m.send(a, r.c, r.f, r.n, bad);
    s = r.c[3] ? status_a : status_b;
    e = {own_addr, 8'h7d, s[15:8], s[7:0]};
    if (r.f == 8'h7e || (r.sup && !r.err)) e.push_back(r.f);
    else e = {e, r.f | 8'h80, r.sup ? r.code : 8'h01};
    for (k = 0; k < r.rl && r.f != 8'h7e; k++) e.push_back(k[7:0] ^ 8'h5a);
    s = 16'hffff;
    foreach (e[j]) s = m.crc(s, e[j]);
    e = {e, s[7:0], s[15:8]};
    bad |= a != own_addr;
    for (k = 0; k < (bad ? 60 : 3000) && m.rq.size() < e.size(); k++) @(posedge clock) #1;
    if (k == 3000) miscompares++;
    if (bad) e.delete();
    else lc = r.c;
    if (!bad && !r.sup && r.f != 8'h7e) icnt++;
    repeat (4) @(posedge clock) #1;
    chk(m.rq.size(), e.size(), "reply length");
    foreach (e[j]) chk(m.rq[j], e[j], "reply byte");
    chk(logic_cmd, lc, "command");
    chk(illegal_fn_count, icnt, "illegal count");
  endtask
  initial begin
    repeat (12) @(posedge clock) #1;
    rst = 0;
    foreach (rows[i]) run(rows[i], own_addr, 0);
    run(rows[1], own_addr, 1);
    run(rows[3], own_addr + 8'h1, 0);
    rst = 1;
    repeat (2) @(posedge clock) #1;
    chk(logic_cmd, 16'h0, "reset command");
    rst = 0;
    {lc, icnt} = 0;
    run(rows[2], own_addr, 0);
    results;
  end
endmodule // tb_top
